// >>> hdl/addr_map_pkg.sv
// address map constants and region codes for the linear address decoder
package addr_map_pkg;
	localparam int ADDR_W = 24;
	localparam int SEG_W = 8;
	localparam int PAGE_W = 2;
	localparam int OFS_W = 16;
	localparam logic [23:0] TOP_REG_LO = 24'hFF_FF00;
	localparam logic [23:0] TOP_REG_HI = 24'hFF_FFFF;
	localparam logic [23:0] TRAP_LO = 24'hF0_0000;
	localparam logic [23:0] TRAP_HI = 24'hFF_FEFF;
	localparam logic [23:0] FLASH_HI = 24'hCB_FFFF;
	localparam logic [23:0] DPR_RES_HI = 24'h00_F5FF;
	localparam logic [23:0] DS_RES_HI = 24'h00_9FFF;
	localparam logic [23:0] EPS_LO = 24'hE8_0000;
	localparam logic [23:0] EPS_HI = 24'hEF_FFFF;
	localparam logic [23:0] PS_LO = 24'hE0_0000;
	localparam logic [23:0] PS_HI = 24'hE7_FFFF;
	localparam logic [23:0] FLASH_LO = 24'hC0_0000;
	localparam logic [23:0] FLASH_RES_LO = 24'hC0_F000;
	localparam logic [23:0] FLASH_RES_HI = 24'hC0_FFFF;
	localparam logic [23:0] EXT_IO_LO = 24'h20_5800;
	localparam logic [23:0] EXT_IO_HI = 24'h3F_FFFF;
	localparam logic [23:0] SER_LO = 24'h20_4000;
	localparam logic [23:0] SER_HI = 24'h20_57FF;
	localparam logic [23:0] CAN_LO = 24'h20_0000;
	localparam logic [23:0] CAN_HI = 24'h20_3FFF;
	localparam logic [23:0] SFA_LO = 24'h00_FE00;
	localparam logic [23:0] DPR_LO = 24'h00_F600;
	localparam logic [23:0] DPR_HI = 24'h00_FDFF;
	localparam logic [23:0] DPR_BIT_LO = 24'h00_FD00;
	localparam logic [23:0] DPR_RES_LO = 24'h00_F200;
	localparam logic [23:0] EFA_LO = 24'h00_F000;
	localparam logic [23:0] EFA_HI = 24'h00_F1FF;
	localparam logic [23:0] XFA_LO = 24'h00_E000;
	localparam logic [23:0] XFA_HI = 24'h00_EFFF;
	localparam logic [23:0] DS_LO = 24'h00_A000;
	localparam logic [23:0] DS_HI = 24'h00_DFFF;
	localparam logic [23:0] DS_SMALL_HI = 24'h00_CFFF;
	localparam logic [23:0] DS_RES_LO = 24'h00_8000;
	localparam logic [23:0] SEG0_HI = 24'h00_FFFF;
	localparam int FLASH_MOD_BIT = 18;
	localparam int SECTOR_BIT = 12;
	localparam int PROG_BLK_BIT = 7;
	localparam logic [1:0] FLASH_MODS = 2'h3;
	typedef enum logic [3:0] {
		RG_EXT_MEM, RG_EXT_IO, RG_SERIAL, RG_CAN, RG_FLASH, RG_PROGRAM_SRAM, RG_EMULATED_PROGRAM_SRAM,
		RG_TOP_REG, RG_TRAP, RG_DATA_SRAM, RG_DUAL_PORT_RAM, RG_SFA, RG_EFA, RG_XFA, RG_RESERVED
	} region_t;
	typedef enum {ST_IDLE, ST_ACCESS, ST_XFER} xfer_state_t;
endpackage

// >>> hdl/region_match.sv
`timescale 1ns/1ps
// inclusive address range comparator, one per map range on the data side, five on the fetch side
module region_match #(
	parameter logic [23:0] LO = 24'h00_0000,
	parameter logic [23:0] HI = 24'h00_0000
) (
	// address in
	input wire logic [23:0] addr,
	// match out
	output logic hit
);
	assign hit = (addr >= LO) && (addr <= HI);
endmodule // region_match

// >>> hdl/linear_address_map_decoder.sv
`timescale 1ns/1ps
// linear address decoder: routes code fetches and data accesses to memories and buses
module linear_address_map_decoder
	import addr_map_pkg::*;
#(
	parameter int FLASH_MODULES = 3,
	parameter bit SMALL_FLASH = 1'b0
) (
	// clock, reset, enable
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic clk_en,
	// code-fetch side request
	input wire logic fetch_req,
	input wire logic [23:0] fetch_addr,
	// data-transfer side request
	input wire logic data_req,
	input wire logic data_we,
	input wire logic data_byte,
	input wire logic data_bit,
	input wire logic [23:0] data_addr,
	// protection state
	input wire logic [15:0] program_sram_prot_limit,
	input wire logic [15:0] flash_wprot_mask,
	input wire logic flash_rprot,
	input wire logic flash_unlocked,
	// code-fetch routing result
	output logic fetch_ack,
	output region_t fetch_region,
	output logic [23:0] fetch_local,
	output logic fetch_flash_wide,
	output logic [1:0] fetch_flash_mod,
	output logic fetch_trap,
	// data routing result
	output logic data_ack,
	output region_t data_region,
	output logic [23:0] data_local,
	output logic data_byte_lane_hi,
	output logic data_bit_ok,
	output logic data_via_sysbus,
	output logic data_via_periph_bus,
	output logic data_no_pipe_opt,
	output logic data_trap,
	output logic [7:0] data_segment,
	output logic [1:0] data_page,
	output logic [11:0] flash_sector,
	output logic [10:0] flash_prog_block,
	output logic data_wr_blocked
);
	logic f_top, f_trap, f_eps, f_ps, f_flash;
	logic d_top, d_trap, d_eps, d_ps, d_flash, d_io, d_ser, d_can;
	logic d_sfa, d_dpr, d_dpres, d_efa, d_xfa, d_ds, d_dsres;
	logic d_flash_res, d_dpr_bit, d_gpr_span;
	region_t f_reg_nxt, d_reg_nxt;
	logic [23:0] f_loc_nxt, d_loc_nxt;
	logic [1:0] d_mod, f_mod;
	logic d_flash_exists, f_flash_exists, d_blk_nxt;
	xfer_state_t f_state_r, d_state_r;

	region_match #(.LO(TOP_REG_LO), .HI(TOP_REG_HI)) u_ftop (.addr(fetch_addr), .hit(f_top));
	region_match #(.LO(TRAP_LO), .HI(TRAP_HI)) u_ftrap (.addr(fetch_addr), .hit(f_trap));
	region_match #(.LO(EPS_LO), .HI(EPS_HI)) u_feps (.addr(fetch_addr), .hit(f_eps));
	region_match #(.LO(PS_LO), .HI(PS_HI)) u_fps (.addr(fetch_addr), .hit(f_ps));
	region_match #(.LO(FLASH_LO), .HI(FLASH_HI)) u_ffl (.addr(fetch_addr), .hit(f_flash));
	region_match #(.LO(TOP_REG_LO), .HI(TOP_REG_HI)) u_dtop (.addr(data_addr), .hit(d_top));
	region_match #(.LO(TRAP_LO), .HI(TRAP_HI)) u_dtrap (.addr(data_addr), .hit(d_trap));
	region_match #(.LO(EPS_LO), .HI(EPS_HI)) u_deps (.addr(data_addr), .hit(d_eps));
	region_match #(.LO(PS_LO), .HI(PS_HI)) u_dps (.addr(data_addr), .hit(d_ps));
	region_match #(.LO(FLASH_LO), .HI(FLASH_HI)) u_dfl (.addr(data_addr), .hit(d_flash));
	region_match #(.LO(EXT_IO_LO), .HI(EXT_IO_HI)) u_dio (.addr(data_addr), .hit(d_io));
	region_match #(.LO(SER_LO), .HI(SER_HI)) u_dser (.addr(data_addr), .hit(d_ser));
	region_match #(.LO(CAN_LO), .HI(CAN_HI)) u_dcan (.addr(data_addr), .hit(d_can));
	region_match #(.LO(SFA_LO), .HI(SEG0_HI)) u_dsfa (.addr(data_addr), .hit(d_sfa));
	region_match #(.LO(DPR_LO), .HI(DPR_HI)) u_ddpr (.addr(data_addr), .hit(d_dpr));
	region_match #(.LO(DPR_RES_LO), .HI(DPR_RES_HI)) u_ddpres (.addr(data_addr), .hit(d_dpres));
	region_match #(.LO(EFA_LO), .HI(EFA_HI)) u_defa (.addr(data_addr), .hit(d_efa));
	region_match #(.LO(XFA_LO), .HI(XFA_HI)) u_dxfa (.addr(data_addr), .hit(d_xfa));
	region_match #(.LO(DS_LO), .HI(DS_HI)) u_dds (.addr(data_addr), .hit(d_ds));
	region_match #(.LO(DS_RES_LO), .HI(DS_RES_HI)) u_ddsres (.addr(data_addr), .hit(d_dsres));
	region_match #(.LO(FLASH_RES_LO), .HI(FLASH_RES_HI)) u_dfres (.addr(data_addr), .hit(d_flash_res));
	region_match #(.LO(DPR_BIT_LO), .HI(DPR_HI)) u_dbit (.addr(data_addr), .hit(d_dpr_bit));

	assign f_mod = fetch_addr[FLASH_MOD_BIT +: 2];
	assign d_mod = data_addr[FLASH_MOD_BIT +: 2];
	// module count is a build option; absent modules fall into reserved space
	assign f_flash_exists = f_flash && (int'(f_mod) < FLASH_MODULES);
	assign d_flash_exists = d_flash && (int'(d_mod) < FLASH_MODULES);
	// any dual-port location counts as register-bank capable, so all of it is bit addressable
	assign d_gpr_span = d_dpr;

	// code-fetch side decode: program memories, the external path, top registers, trap and reserved space only
	always_comb begin
		f_reg_nxt = RG_EXT_MEM;
		f_loc_nxt = fetch_addr;
		if (f_top) begin
			f_reg_nxt = RG_TOP_REG;
		end else if (f_trap) begin
			f_reg_nxt = RG_TRAP;
		end else if (f_eps) begin
			f_reg_nxt = RG_EMULATED_PROGRAM_SRAM;
			f_loc_nxt = {8'h00, fetch_addr[OFS_W-1:0]};
		end else if (f_ps) begin
			f_reg_nxt = RG_PROGRAM_SRAM;
			f_loc_nxt = {8'h00, fetch_addr[OFS_W-1:0]};
		end else if (f_flash_exists) begin
			f_reg_nxt = RG_FLASH;
			f_loc_nxt = fetch_addr - FLASH_LO;
		end else if (fetch_addr >= FLASH_LO) begin
			f_reg_nxt = RG_RESERVED;
		end
	end

	// data side decode, segment 0 internal memories last, after the high regions and buses
	always_comb begin
		d_reg_nxt = RG_EXT_MEM;
		d_loc_nxt = data_addr;
		if (d_top) begin
			d_reg_nxt = RG_TOP_REG;
		end else if (d_trap) begin
			d_reg_nxt = RG_TRAP;
		end else if (d_eps) begin
			d_reg_nxt = RG_EMULATED_PROGRAM_SRAM;
			d_loc_nxt = {8'h00, data_addr[OFS_W-1:0]};
		end else if (d_ps) begin
			d_reg_nxt = RG_PROGRAM_SRAM;
			d_loc_nxt = {8'h00, data_addr[OFS_W-1:0]};
		end else if (d_flash_exists) begin
			d_reg_nxt = RG_FLASH;
			d_loc_nxt = data_addr - FLASH_LO;
		end else if (data_addr >= FLASH_LO) begin
			d_reg_nxt = RG_RESERVED;
		end else if (d_io) begin
			d_reg_nxt = RG_EXT_IO;
		end else if (d_ser) begin
			d_reg_nxt = RG_SERIAL;
			d_loc_nxt = data_addr - SER_LO;
		end else if (d_can) begin
			d_reg_nxt = RG_CAN;
			d_loc_nxt = data_addr - CAN_LO;
		end else if (d_sfa) begin
			d_reg_nxt = RG_SFA;
			d_loc_nxt = data_addr - SFA_LO;
		end else if (d_dpr) begin
			d_reg_nxt = RG_DUAL_PORT_RAM;
			d_loc_nxt = data_addr - DPR_LO;
		end else if (d_efa) begin
			d_reg_nxt = RG_EFA;
			d_loc_nxt = data_addr - EFA_LO;
		end else if (d_xfa) begin
			d_reg_nxt = RG_XFA;
			d_loc_nxt = data_addr - XFA_LO;
		end else if (d_ds) begin
			// small-flash variants only populate 12 Kbytes
			if (SMALL_FLASH && data_addr > DS_SMALL_HI) begin
				d_reg_nxt = RG_RESERVED;
			end else begin
				d_reg_nxt = RG_DATA_SRAM;
				d_loc_nxt = data_addr - DS_LO;
			end
		end else if (d_dpres || d_dsres) begin
			d_reg_nxt = RG_RESERVED;
		end
	end

	// access blocking: protected program SRAM writes, reserved flash sector writes, clustered flash write protection, flash read protection
	always_comb begin
		d_blk_nxt = 1'b0;
		if (data_we && (d_reg_nxt == RG_PROGRAM_SRAM) && (data_addr[OFS_W-1:0] < program_sram_prot_limit)) begin
			d_blk_nxt = 1'b1;
		end else if (data_we && d_flash_res) begin
			d_blk_nxt = 1'b1;
		end else if (data_we && (d_reg_nxt == RG_FLASH)
			&& flash_wprot_mask[data_addr[SECTOR_BIT+3 -: 4]] && !flash_unlocked) begin
			d_blk_nxt = 1'b1;
		end else if (!data_we && (d_reg_nxt == RG_FLASH) && flash_rprot && !flash_unlocked) begin
			d_blk_nxt = 1'b1;
		end
		// byte writes to function areas stay legal: every location takes byte access
	end

	// code-fetch handshake: one-cycle decode then acknowledge
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			f_state_r <= ST_IDLE;
			fetch_ack <= 1'b0;
			fetch_region <= RG_EXT_MEM;
			fetch_local <= 24'h00_0000;
			fetch_flash_wide <= 1'b0;
			fetch_flash_mod <= 2'h0;
			fetch_trap <= 1'b0;
		end else if (clk_en) begin
			fetch_ack <= 1'b0;
			case (f_state_r)
				ST_IDLE: begin
					if (fetch_req) begin
						f_state_r <= ST_ACCESS;
						fetch_ack <= 1'b1;
						fetch_region <= f_reg_nxt;
						fetch_local <= f_loc_nxt;
						fetch_flash_wide <= (f_reg_nxt == RG_FLASH);
						fetch_flash_mod <= f_mod;
						fetch_trap <= (f_reg_nxt == RG_TRAP);
					end
				end
				default: begin
					f_state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// data handshake runs independently, so both units proceed at once
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			d_state_r <= ST_IDLE;
			data_ack <= 1'b0;
			data_region <= RG_EXT_MEM;
			data_local <= 24'h00_0000;
			data_byte_lane_hi <= 1'b0;
			data_bit_ok <= 1'b0;
			data_via_sysbus <= 1'b0;
			data_via_periph_bus <= 1'b0;
			data_no_pipe_opt <= 1'b0;
			data_trap <= 1'b0;
			data_segment <= 8'h00;
			data_page <= 2'h0;
			flash_sector <= 12'h000;
			flash_prog_block <= 11'h000;
			data_wr_blocked <= 1'b0;
		end else if (clk_en) begin
			data_ack <= 1'b0;
			case (d_state_r)
				ST_IDLE: begin
					if (data_req) begin
						d_state_r <= ST_ACCESS;
						data_ack <= 1'b1;
						data_region <= d_reg_nxt;
						data_local <= d_loc_nxt;
						data_byte_lane_hi <= data_byte & data_addr[0];
						data_bit_ok <= data_bit && (d_dpr_bit || d_gpr_span
							|| d_reg_nxt == RG_SFA || d_reg_nxt == RG_EFA);
						data_via_sysbus <= (d_reg_nxt == RG_FLASH || d_reg_nxt == RG_PROGRAM_SRAM
							|| d_reg_nxt == RG_EMULATED_PROGRAM_SRAM || d_reg_nxt == RG_EXT_MEM
							|| d_reg_nxt == RG_EXT_IO || d_reg_nxt == RG_SERIAL
							|| d_reg_nxt == RG_CAN);
						data_via_periph_bus <= (d_reg_nxt == RG_SERIAL
							|| d_reg_nxt == RG_CAN);
						data_no_pipe_opt <= (d_reg_nxt == RG_EXT_IO);
						data_trap <= (d_reg_nxt == RG_TRAP);
						data_segment <= data_addr[ADDR_W-1 -: SEG_W];
						data_page <= data_addr[OFS_W-1 -: PAGE_W];
						flash_sector <= data_addr[ADDR_W-1:SECTOR_BIT];
						flash_prog_block <= {2'b00, data_addr[SECTOR_BIT+3:PROG_BLK_BIT]};
						data_wr_blocked <= d_blk_nxt;
					end
				end
				default: begin
					d_state_r <= ST_IDLE;
				end
			endcase
		end
	end

	a_trap_flag: assert property (@(posedge ref_clk) disable iff (srst)
		clk_en && data_req && d_state_r == ST_IDLE && d_trap && !d_top |=> data_trap && data_ack)
		else $error("trap range did not raise trap");
	a_io_nopipe: assert property (@(posedge ref_clk) disable iff (srst)
		clk_en && data_req && d_state_r == ST_IDLE && d_io |=> data_no_pipe_opt)
		else $error("external io kept pipeline optimizations");
	a_periph_route: assert property (@(posedge ref_clk) disable iff (srst)
		clk_en && data_req && d_state_r == ST_IDLE && (d_ser || d_can) |=> data_via_periph_bus)
		else $error("serial or can block not on peripheral bus");
	a_program_sram_alias: assert property (@(posedge ref_clk) disable iff (srst)
		clk_en && fetch_req && f_state_r == ST_IDLE && f_ps
		|=> fetch_local == {8'h00, $past(fetch_addr[15:0])})
		else $error("program sram mirror not modulo 64k");
	a_flash_res_wr: assert property (@(posedge ref_clk) disable iff (srst)
		clk_en && data_req && data_we && d_state_r == ST_IDLE && d_flash_res |=> data_wr_blocked)
		else $error("reserved flash sector writable");
	a_program_sram_prot: assert property (@(posedge ref_clk) disable iff (srst)
		clk_en && data_req && data_we && d_state_r == ST_IDLE && d_ps && !d_eps
		&& data_addr[15:0] < program_sram_prot_limit |=> data_wr_blocked)
		else $error("protected program sram writable");
	a_seg_page: assert property (@(posedge ref_clk) disable iff (srst)
		clk_en && data_req && d_state_r == ST_IDLE
		|=> data_segment == $past(data_addr[23:16]) && data_page == $past(data_addr[15:14]))
		else $error("segment or page split wrong");
	a_ack_single: assert property (@(posedge ref_clk) disable iff (srst)
		fetch_ack |=> !fetch_ack)
		else $error("fetch ack longer than one cycle");
	a_dpr_bit: assert property (@(posedge ref_clk) disable iff (srst)
		clk_en && data_req && data_bit && d_state_r == ST_IDLE && d_dpr_bit |=> data_bit_ok)
		else $error("top dual-port bytes not bit addressable");
endmodule // linear_address_map_decoder

// >>> testbench/core_unit_model.sv
`timescale 1ns/1ps
// model of the core's code-fetch and data-transfer requesters
module core_unit_model (
	// clock
	input wire logic ref_clk,
	// code-fetch side
	output logic fetch_req,
	output logic [23:0] fetch_addr,
	input wire logic fetch_ack,
	// data side
	output logic data_req,
	output logic data_we,
	output logic data_byte,
	output logic data_bit,
	output logic [23:0] data_addr,
	input wire logic data_ack
);
	int timeouts = 0;
	initial begin
		fetch_req = 1'b0;
		fetch_addr = 24'h00_0000;
		data_req = 1'b0;
		data_we = 1'b0;
		data_byte = 1'b0;
		data_bit = 1'b0;
		data_addr = 24'h00_0000;
	end
	// request held until ack is seen or 8 cycles pass; the address is then inverted so nothing leans on a stale one
	task automatic fetch(input logic [23:0] a);
		int n;
		@(negedge ref_clk);
		fetch_req = 1'b1;
		fetch_addr = a;
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (fetch_ack !== 1'b1 && n < 8);
		if (n >= 8) timeouts++;
		fetch_req = 1'b0;
		fetch_addr = ~a;
	endtask
	// callers also read reserved and trap ranges and write the reserved flash sector
	task automatic data_xfer(input logic [23:0] a, input logic we, input logic byt, input logic bt);
		int n;
		@(negedge ref_clk);
		data_req = 1'b1;
		data_addr = a;
		data_we = we;
		data_byte = byt;
		data_bit = bt;
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (data_ack !== 1'b1 && n < 8);
		if (n >= 8) timeouts++;
		data_req = 1'b0;
		data_addr = ~a;
		data_we = ~we;
	endtask
endmodule // core_unit_model

// >>> testbench/linear_address_map_decoder_test.sv
`timescale 1ns/1ps
// self-checking bench for the linear address decoder
module linear_address_map_decoder_test import addr_map_pkg::*;;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic clk_en = 1'b1;
	logic [15:0] program_sram_prot_limit = 16'h0000;
	logic [15:0] flash_wprot_mask = 16'h0000;
	logic flash_rprot = 1'b0;
	logic flash_unlocked = 1'b0;
	logic fetch_req, data_req, data_we, data_byte, data_bit;
	logic [23:0] fetch_addr, data_addr, fetch_local, data_local;
	logic fetch_ack, fetch_flash_wide, fetch_trap, data_ack, data_byte_lane_hi, data_bit_ok;
	logic data_via_sysbus, data_via_periph_bus, data_no_pipe_opt, data_trap, data_wr_blocked;
	logic [1:0] fetch_flash_mod, data_page;
	logic [7:0] data_segment;
	logic [11:0] flash_sector;
	logic [10:0] flash_prog_block;
	region_t fetch_region, data_region;
	int n_mismatch = 0;
	int tests_run = 0;
	logic [23:0] map_addr [31] = '{24'h00_0100, 24'h00_7FFF, 24'h00_8000, 24'h00_A000,
		24'h00_DFFE, 24'h00_E000, 24'h00_F000, 24'h00_F200, 24'h00_F600, 24'h00_FDFE,
		24'h00_FE00, 24'h00_FFFE, 24'h01_0000, 24'h20_0000, 24'h20_3FFE, 24'h20_4000,
		24'h20_57FE, 24'h20_5800, 24'h3F_FFFE, 24'h40_0000, 24'hBF_FFFE, 24'hC0_0000,
		24'hCB_FFFE, 24'hCC_0000, 24'hE0_0000, 24'hE1_2344, 24'hE8_0000, 24'hEF_FFFE,
		24'hF0_0000, 24'hFF_FEFE, 24'hFF_FF00};
	region_t map_rg [31] = '{RG_EXT_MEM, RG_EXT_MEM, RG_RESERVED, RG_DATA_SRAM, RG_DATA_SRAM, RG_XFA,
		RG_EFA, RG_RESERVED, RG_DUAL_PORT_RAM, RG_DUAL_PORT_RAM, RG_SFA, RG_SFA, RG_EXT_MEM, RG_CAN, RG_CAN,
		RG_SERIAL, RG_SERIAL, RG_EXT_IO, RG_EXT_IO, RG_EXT_MEM, RG_EXT_MEM, RG_FLASH, RG_FLASH,
		RG_RESERVED, RG_PROGRAM_SRAM, RG_PROGRAM_SRAM, RG_EMULATED_PROGRAM_SRAM, RG_EMULATED_PROGRAM_SRAM, RG_TRAP, RG_TRAP, RG_TOP_REG};

	always #20 ref_clk = ~ref_clk;

	linear_address_map_decoder uut (.ref_clk(ref_clk), .srst(srst), .clk_en(clk_en),
		.fetch_req(fetch_req), .fetch_addr(fetch_addr), .data_req(data_req), .data_we(data_we),
		.data_byte(data_byte), .data_bit(data_bit), .data_addr(data_addr),
		.program_sram_prot_limit(program_sram_prot_limit), .flash_wprot_mask(flash_wprot_mask),
		.flash_rprot(flash_rprot), .flash_unlocked(flash_unlocked), .fetch_ack(fetch_ack),
		.fetch_region(fetch_region), .fetch_local(fetch_local),
		.fetch_flash_wide(fetch_flash_wide), .fetch_flash_mod(fetch_flash_mod),
		.fetch_trap(fetch_trap), .data_ack(data_ack), .data_region(data_region),
		.data_local(data_local), .data_byte_lane_hi(data_byte_lane_hi),
		.data_bit_ok(data_bit_ok), .data_via_sysbus(data_via_sysbus),
		.data_via_periph_bus(data_via_periph_bus), .data_no_pipe_opt(data_no_pipe_opt),
		.data_trap(data_trap), .data_segment(data_segment), .data_page(data_page),
		.flash_sector(flash_sector), .flash_prog_block(flash_prog_block),
		.data_wr_blocked(data_wr_blocked));

	core_unit_model mdl (.ref_clk(ref_clk), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
		.fetch_ack(fetch_ack), .data_req(data_req), .data_we(data_we), .data_byte(data_byte),
		.data_bit(data_bit), .data_addr(data_addr), .data_ack(data_ack));

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic stop_test();
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// used at start and again mid-run to prove a second reset clears held results
	task automatic reset_dut();
		@(negedge ref_clk);
		srst = 1'b1;
		repeat (2) @(negedge ref_clk);
		srst = 1'b0;
		check("data_region", data_region, RG_EXT_MEM);
		check("data_trap", data_trap, 1'b0);
		check("fetch_ack", fetch_ack, 1'b0);
	endtask

	task automatic map_walk();
		logic [23:0] a;
		region_t r;
		for (int i = 0; i < 31; i++) begin
			a = map_addr[i];
			r = map_rg[i];
			mdl.data_xfer(a, 1'b0, 1'b0, 1'b0);
			check("data_region", data_region, r);
			check("data_segment", data_segment, a[23:16]);
			check("data_page", data_page, a[15:14]);
			check("data_no_pipe_opt", data_no_pipe_opt, r == RG_EXT_IO);
			check("data_via_periph_bus", data_via_periph_bus, r inside {RG_SERIAL, RG_CAN});
			check("data_trap", data_trap, r == RG_TRAP);
			if (r inside {RG_PROGRAM_SRAM, RG_EMULATED_PROGRAM_SRAM}) check("data_local", data_local, {8'h00, a[15:0]});
			if (!(r inside {RG_RESERVED, RG_TRAP, RG_TOP_REG}))
				check("data_via_sysbus", data_via_sysbus,
					!(r inside {RG_DATA_SRAM, RG_DUAL_PORT_RAM, RG_SFA, RG_EFA, RG_XFA}));
			if (a >= FLASH_LO) begin
				mdl.fetch(a);
				check("fetch_region", fetch_region, r);
				check("fetch_trap", fetch_trap, r == RG_TRAP);
				check("fetch_flash_wide", fetch_flash_wide, r == RG_FLASH);
				if (r == RG_FLASH) check("fetch_flash_mod", fetch_flash_mod, a[19:18]);
			end
		end
	endtask

	// both units at once, then a request made while the clock enable is low
	task automatic concurrent();
		fork
			mdl.fetch(24'hC4_0010);
			mdl.data_xfer(24'h20_6000, 1'b1, 1'b0, 1'b0);
		join
		check("fetch_flash_mod", fetch_flash_mod, 2'h1);
		check("data_region", data_region, RG_EXT_IO);
		check("data_via_sysbus", data_via_sysbus, 1'b1);
		// let the ack pulse clear first, or the freeze would hold it high
		@(negedge ref_clk);
		clk_en = 1'b0;
		fork
			mdl.data_xfer(24'h00_A002, 1'b0, 1'b0, 1'b0);
			begin
				repeat (4) @(negedge ref_clk);
				check("data_ack", data_ack, 1'b0);
				clk_en = 1'b1;
			end
		join
		check("data_region", data_region, RG_DATA_SRAM);
	endtask

	task automatic access_kinds();
		mdl.data_xfer(24'h00_F601, 1'b0, 1'b1, 1'b0);
		check("data_byte_lane_hi", data_byte_lane_hi, 1'b1);
		mdl.data_xfer(24'h00_A001, 1'b1, 1'b1, 1'b0);
		check("data_wr_blocked", data_wr_blocked, 1'b0);
		mdl.data_xfer(24'h00_F600, 1'b0, 1'b1, 1'b0);
		check("data_byte_lane_hi", data_byte_lane_hi, 1'b0);
		mdl.data_xfer(24'h00_FD00, 1'b0, 1'b0, 1'b1);
		check("data_bit_ok", data_bit_ok, 1'b1);
		mdl.data_xfer(24'h00_F600, 1'b0, 1'b0, 1'b1);
		check("data_bit_ok", data_bit_ok, 1'b1);
		mdl.data_xfer(24'h00_A000, 1'b0, 1'b0, 1'b1);
		check("data_bit_ok", data_bit_ok, 1'b0);
		mdl.data_xfer(24'h00_FE10, 1'b1, 1'b1, 1'b0);
		check("data_wr_blocked", data_wr_blocked, 1'b0);
		mdl.data_xfer(24'h00_FE10, 1'b1, 1'b0, 1'b0);
		check("data_wr_blocked", data_wr_blocked, 1'b0);
	endtask

	task automatic prot_case(input logic [23:0] a, input logic we, input logic exp);
		mdl.data_xfer(a, we, 1'b0, 1'b0);
		check("data_wr_blocked", data_wr_blocked, exp);
	endtask

	task automatic protection();
		program_sram_prot_limit = 16'h1000;
		flash_wprot_mask = 16'h0004;
		prot_case(24'hE0_0FFE, 1'b1, 1'b1);
		prot_case(24'hE0_1000, 1'b1, 1'b0);
		prot_case(24'hE0_0800, 1'b0, 1'b0);
		prot_case(24'hC0_F000, 1'b1, 1'b1);
		prot_case(24'hC0_FFFE, 1'b1, 1'b1);
		prot_case(24'hC0_2000, 1'b1, 1'b1);
		prot_case(24'hC4_2FFE, 1'b1, 1'b1);
		prot_case(24'hC0_3000, 1'b1, 1'b0);
		mdl.data_xfer(24'hC8_2F80, 1'b0, 1'b0, 1'b0);
		check("flash_sector", flash_sector, 12'hC82);
		check("flash_prog_block", flash_prog_block[8:0], 9'h05F);
		flash_unlocked = 1'b1;
		prot_case(24'hC0_2000, 1'b1, 1'b0);
		flash_rprot = 1'b1;
		prot_case(24'hC0_4000, 1'b0, 1'b0);
		flash_unlocked = 1'b0;
		prot_case(24'hC0_4000, 1'b0, 1'b1);
		flash_rprot = 1'b0;
	endtask

	initial begin
		#(40 * 4000);
		n_mismatch++;
		stop_test();
	end

	initial begin
		reset_dut();
		map_walk();
		concurrent();
		reset_dut();
		access_kinds();
		protection();
		check("partner_waits", mdl.timeouts, 0);
		stop_test();
	end
endmodule // linear_address_map_decoder_test
